// file: logic/msev_dir_hold.sv
// holds a one-direction motion block from a trigger until release
// assumes evt_flag is the sticky event bit of the same trigger
module msev_dir_hold
  import msev_pkg::*;
#(
  parameter bit LATCH_REL = 1'b0
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // trigger and release
  input  wire logic trig,
  input  wire logic evt_flag,
  input  wire logic rel_now,
  // block state
  output logic      hold,
  output logic      hold_next
);

  typedef struct packed {
    logic hold;
    logic rel_seen;
  } msev_hold_st_t;

  msev_hold_st_t st_ff;
  msev_hold_st_t nxt_st;

  // a release pulse may come before software clears the event, so keep it
  always_comb begin
    nxt_st = st_ff;
    if (trig) begin
      nxt_st.hold     = 1'b1;
      nxt_st.rel_seen = 1'b0;
    end else if (st_ff.hold) begin
      if (LATCH_REL && rel_now) begin
        nxt_st.rel_seen = 1'b1;
      end
      if (!evt_flag && (rel_now || st_ff.rel_seen)) begin
        nxt_st.hold     = 1'b0;
        nxt_st.rel_seen = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hold      = st_ff.hold;
  assign hold_next = nxt_st.hold;

endmodule

// file: logic/msev_edge.sv
// rising-edge detector over a vector of condition levels
// assumes levels are synchronous to core_clk
module msev_edge
  import msev_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // levels in, one-cycle rises out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } msev_edge_st_t;

  msev_edge_st_t st_ff;
  msev_edge_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = level;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise = level & ~st_ff.prev;

endmodule

// file: logic/msev_pkg.sv
// holds the register map, event bit positions, reset values and carrier types
// assumes one clock domain; all event conditions arrive synchronous to core_clk
package msev_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned STAT_W         = 8;
  localparam logic [6:0]  ADDR_SPI_SEL   = 7'h0B;
  localparam logic [6:0]  ADDR_PROTECT   = 7'h0C;
  localparam logic [6:0]  ADDR_INT_SEL   = 7'h0D;
  localparam logic [6:0]  ADDR_EVENTS    = 7'h0E;

  localparam logic [31:0] RST_SPI_SEL    = 32'h8202_9805;
  localparam logic [31:0] RST_PROTECT    = 32'h0000_0000;
  localparam logic [31:0] RST_INT_SEL    = 32'h0000_0000;
  // reset-seen bit comes up set so software can tell a reset happened
  localparam logic [31:0] RST_EVENTS     = 32'h8000_0000;
  localparam logic [31:0] EV_RSVD_MASK   = 32'h0040_0000;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ------------------------------------------------------------
  // event bit positions
  // ------------------------------------------------------------
  localparam int unsigned EV_TARGET      = 0;
  localparam int unsigned EV_POS_COMP    = 1;
  localparam int unsigned EV_TOP_SPEED   = 2;
  localparam int unsigned EV_SPD_ZERO    = 3;
  localparam int unsigned EV_SPD_POS     = 4;
  localparam int unsigned EV_SPD_NEG     = 5;
  localparam int unsigned EV_RAMP_CONST  = 6;
  localparam int unsigned EV_RAMP_ACC    = 7;
  localparam int unsigned EV_RAMP_DEC    = 8;
  localparam int unsigned EV_TRAP_MAX    = 9;
  localparam int unsigned EV_FREEZE      = 10;
  localparam int unsigned EV_LEFT_SW     = 11;
  localparam int unsigned EV_RIGHT_SW    = 12;
  localparam int unsigned EV_LEFT_SOFT   = 13;
  localparam int unsigned EV_RIGHT_SOFT  = 14;
  localparam int unsigned EV_HOME_ERR    = 15;
  localparam int unsigned EV_POS_CAPT    = 16;
  localparam int unsigned EV_FULLSTEP    = 17;
  localparam int unsigned EV_ENC_DEV     = 18;
  localparam int unsigned EV_INDEX       = 19;
  localparam int unsigned EV_ENC_CAPT    = 20;
  localparam int unsigned EV_SER_ERR     = 21;
  localparam int unsigned EV_SER_CFG     = 23;
  localparam int unsigned EV_SER_FLAG    = 24;
  localparam int unsigned EV_DGRAM       = 25;
  localparam int unsigned EV_ENC_ZERO    = 26;
  localparam int unsigned EV_COMM_MAX    = 27;
  localparam int unsigned EV_LOOP_FIT    = 28;
  localparam int unsigned EV_STALL       = 29;
  localparam int unsigned EV_DRV_FLAG    = 30;
  localparam int unsigned EV_RESET       = 31;

  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [1:0]  CODE_ZERO      = 2'h0;
  localparam logic [1:0]  CODE_UP        = 2'h1;
  localparam logic [1:0]  CODE_DOWN      = 2'h2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } msev_reg_req_t;

  typedef struct packed {
    logic        target_hit;
    logic        pos_compare_hit;
    logic        top_speed_hit;
    logic [1:0]  speed_sign_code;
    logic [1:0]  ramp_code;
    logic        trap_at_limit;
    logic [31:0] present_speed;
    logic [31:0] break_speed;
    logic        freeze_input_n;
    logic        left_end_switch;
    logic        right_end_switch;
    logic        left_switch_en;
    logic        right_switch_en;
    logic        left_soft_limit;
    logic        right_soft_limit;
    logic        left_limit_en;
    logic        right_limit_en;
    logic        left_limit_written;
    logic        right_limit_written;
    logic        home_mismatch;
    logic        home_outside_margin;
    logic        position_capture_event;
    logic        fullstep_mode_event;
    logic        encoder_deviation_event;
    logic        index_event;
    logic        encoder_capture_event;
    logic        serial_encoder_error_event;
    logic        serial_encoder_config_event;
    logic [3:0]  serial_encoder_flag_bits;
    logic        driver_datagram_sent;
    logic        encoder_speed_zero_event;
    logic        commutation_angle_limit_event;
    logic        loop_deviation_inner_event;
    logic        stall_stop;
    logic        driver_flag_event;
  } msev_cond_t;

endpackage

// file: logic/msev_top.sv
// sticky motion status event register with read-clear, protection,
// interrupt and spi status forwarding, and direction blocking
// assumes register port and all condition levels are synchronous to core_clk
//
// What this block does
// - set bits 0-2 on target, compare, top speed
// - set bits 3-5 when speed sign code changes
// - set bits 6-8 when ramp code changes
// - set bit 9 on trapezoid limit above break
// - bit 10 on freeze low; motion stops until reset
// - bit 11 left switch; block negative until released
// - bit 12 right switch; block positive until released
// - bit 13 left soft limit; block negative until released
// - bit 14 right soft limit; block positive until released
// - bit 15 on home polarity error outside margin
// - bit 16 on position capture or homing done
// - bit 17 when fullstep mode becomes active
// - bits 18-20 encoder deviation, index, capture
// - bits 21,23,24 serial encoder events; 22 reserved
// - bit 25 per datagram sent to driver
// - bits 26-28 encoder zero, angle max, loop fit
// - bit 29 on stall that stopped ramp
// - bit 30 on selected driver flag
// - bit 31 set by reset
// - read clears events except protected bits
// - interrupt when any selected event active
// - selected events 0-7 drive the eight spi status bits
module msev_top
  import msev_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          srst,
  // register access
  input  wire msev_reg_req_t reg_req,
  output logic [31:0]        reg_rdata,
  // event conditions
  input  wire msev_cond_t    cond,
  // status outputs
  output logic [7:0]         spi_status,
  output logic               interrupt_output,
  output logic               motion_neg_block,
  output logic               motion_pos_block,
  output logic               motion_freeze_event
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] events;
    logic [31:0] spi_sel;
    logic [31:0] protect;
    logic [31:0] int_sel;
    logic [31:0] rdata;
    logic [7:0]  spi_status;
    logic        irq;
    logic        freeze_event;
    logic        neg_block;
    logic        pos_block;
  } msev_top_st_t;

  msev_top_st_t st_ff;
  msev_top_st_t nxt_st;

  logic [31:0] level;
  logic [31:0] rise;
  logic [31:0] spd_mag;
  logic        hold_l;
  logic        hold_r;
  logic        hold_vl;
  logic        hold_vr;
  logic        nxt_hold_l;
  logic        nxt_hold_r;
  logic        nxt_hold_vl;
  logic        nxt_hold_vr;
  logic        rd_events;

  // ------------------------------------------------------------
  // condition levels
  // ------------------------------------------------------------
  always_comb begin
    spd_mag = cond.present_speed;
    if (cond.present_speed[31]) begin
      spd_mag = 32'h0000_0000 - cond.present_speed;
    end
    level                = '0;
    level[EV_TARGET]     = cond.target_hit;
    level[EV_POS_COMP]   = cond.pos_compare_hit;
    level[EV_TOP_SPEED]  = cond.top_speed_hit;
    level[EV_SPD_ZERO]   = (cond.speed_sign_code == CODE_ZERO);
    level[EV_SPD_POS]    = (cond.speed_sign_code == CODE_UP);
    level[EV_SPD_NEG]    = (cond.speed_sign_code == CODE_DOWN);
    level[EV_RAMP_CONST] = (cond.ramp_code == CODE_ZERO);
    level[EV_RAMP_ACC]   = (cond.ramp_code == CODE_UP);
    level[EV_RAMP_DEC]   = (cond.ramp_code == CODE_DOWN);
    level[EV_TRAP_MAX]   = cond.trap_at_limit && (cond.break_speed != ZERO_WORD)
                           && (spd_mag > cond.break_speed);
    level[EV_FREEZE]     = !cond.freeze_input_n;
    level[EV_LEFT_SW]    = cond.left_end_switch && cond.left_switch_en;
    level[EV_RIGHT_SW]   = cond.right_end_switch && cond.right_switch_en;
    level[EV_LEFT_SOFT]  = cond.left_soft_limit && cond.left_limit_en;
    level[EV_RIGHT_SOFT] = cond.right_soft_limit && cond.right_limit_en;
    level[EV_HOME_ERR]   = cond.home_mismatch && cond.home_outside_margin;
    level[EV_POS_CAPT]   = cond.position_capture_event;
    level[EV_FULLSTEP]   = cond.fullstep_mode_event;
    level[EV_ENC_DEV]    = cond.encoder_deviation_event;
    level[EV_INDEX]      = cond.index_event;
    level[EV_ENC_CAPT]   = cond.encoder_capture_event;
    level[EV_SER_ERR]    = cond.serial_encoder_error_event;
    level[EV_SER_CFG]    = cond.serial_encoder_config_event;
    level[EV_SER_FLAG]   = |cond.serial_encoder_flag_bits;
    level[EV_DGRAM]      = cond.driver_datagram_sent;
    level[EV_ENC_ZERO]   = cond.encoder_speed_zero_event;
    level[EV_COMM_MAX]   = cond.commutation_angle_limit_event;
    level[EV_LOOP_FIT]   = cond.loop_deviation_inner_event;
    level[EV_STALL]      = cond.stall_stop;
    level[EV_DRV_FLAG]   = cond.driver_flag_event;
  end

  // level inputs: back-to-back datagram pulses merge into one rise
  msev_edge #(
    .WIDTH (32)
  ) u_edge (
    .core_clk (core_clk),
    .srst     (srst),
    .level    (level),
    .rise     (rise)
  );

  // ------------------------------------------------------------
  // direction holds
  // ------------------------------------------------------------
  msev_dir_hold #(.LATCH_REL (1'b0)) u_hold_l (
    .core_clk  (core_clk),
    .srst      (srst),
    .trig      (rise[EV_LEFT_SW]),
    .evt_flag  (st_ff.events[EV_LEFT_SW]),
    .rel_now   (!cond.left_end_switch || !cond.left_switch_en),
    .hold      (hold_l),
    .hold_next (nxt_hold_l)
  );

  msev_dir_hold #(.LATCH_REL (1'b0)) u_hold_r (
    .core_clk  (core_clk),
    .srst      (srst),
    .trig      (rise[EV_RIGHT_SW]),
    .evt_flag  (st_ff.events[EV_RIGHT_SW]),
    .rel_now   (!cond.right_end_switch || !cond.right_switch_en),
    .hold      (hold_r),
    .hold_next (nxt_hold_r)
  );

  msev_dir_hold #(.LATCH_REL (1'b1)) u_hold_vl (
    .core_clk  (core_clk),
    .srst      (srst),
    .trig      (rise[EV_LEFT_SOFT]),
    .evt_flag  (st_ff.events[EV_LEFT_SOFT]),
    .rel_now   (cond.left_limit_written || !cond.left_limit_en),
    .hold      (hold_vl),
    .hold_next (nxt_hold_vl)
  );

  msev_dir_hold #(.LATCH_REL (1'b1)) u_hold_vr (
    .core_clk  (core_clk),
    .srst      (srst),
    .trig      (rise[EV_RIGHT_SOFT]),
    .evt_flag  (st_ff.events[EV_RIGHT_SOFT]),
    .rel_now   (cond.right_limit_written || !cond.right_limit_en),
    .hold      (hold_vr),
    .hold_next (nxt_hold_vr)
  );

  // ------------------------------------------------------------
  // registers and next state
  // ------------------------------------------------------------
  assign rd_events = reg_req.rd && (reg_req.addr == ADDR_EVENTS);

  always_comb begin
    nxt_st = st_ff;
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_SPI_SEL: nxt_st.spi_sel = reg_req.wdata;
        ADDR_PROTECT: nxt_st.protect = reg_req.wdata;
        ADDR_INT_SEL: nxt_st.int_sel = reg_req.wdata;
        default:      nxt_st.spi_sel = st_ff.spi_sel;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_SPI_SEL: nxt_st.rdata = st_ff.spi_sel;
        ADDR_PROTECT: nxt_st.rdata = st_ff.protect;
        ADDR_INT_SEL: nxt_st.rdata = st_ff.int_sel;
        ADDR_EVENTS:  nxt_st.rdata = st_ff.events;
        default:      nxt_st.rdata = ZERO_WORD;
      endcase
    end
    // protected bits survive the read; fresh rises win over the clear
    if (rd_events) begin
      nxt_st.events = st_ff.events & st_ff.protect;
    end
    nxt_st.events = (nxt_st.events | rise) & ~EV_RSVD_MASK;
    nxt_st.freeze_event = st_ff.freeze_event || rise[EV_FREEZE];
    nxt_st.irq        = |(nxt_st.events & nxt_st.int_sel);
    nxt_st.spi_status = nxt_st.events[7:0] & nxt_st.spi_sel[7:0];
    nxt_st.neg_block  = nxt_hold_l || nxt_hold_vl || nxt_st.freeze_event;
    nxt_st.pos_block  = nxt_hold_r || nxt_hold_vr || nxt_st.freeze_event;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff            <= '0;
      st_ff.events     <= RST_EVENTS;
      st_ff.spi_sel    <= RST_SPI_SEL;
      st_ff.protect    <= RST_PROTECT;
      st_ff.int_sel    <= RST_INT_SEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata        = st_ff.rdata;
  assign spi_status       = st_ff.spi_status;
  assign interrupt_output = st_ff.irq;
  assign motion_neg_block = st_ff.neg_block;
  assign motion_pos_block = st_ff.pos_block;
  assign motion_freeze_event    = st_ff.freeze_event;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_read_ev;
    rd_events ##1 1'b1;
  endsequence

  // release steps: event cleared, then switch off or limit disabled
  sequence s_left_sw_free;
    hold_l && !st_ff.events[EV_LEFT_SW] && !cond.left_end_switch;
  endsequence

  sequence s_left_soft_free;
    hold_vl && !st_ff.events[EV_LEFT_SOFT] && !cond.left_limit_en;
  endsequence

  AST_SET_BITS: assert property ((rise & ~EV_RSVD_MASK) != ZERO_WORD |=>
    ((st_ff.events & $past(rise) & ~EV_RSVD_MASK) == ($past(rise) & ~EV_RSVD_MASK)))
    else $error("event rise not latched");
  AST_READ_CLEAR: assert property (s_read_ev |->
    (st_ff.events == (($past(st_ff.events) & $past(st_ff.protect)) |
                      ($past(rise) & ~EV_RSVD_MASK))))
    else $error("read clear wrong");
  AST_READ_DATA: assert property (rd_events |=> (reg_rdata == $past(st_ff.events)))
    else $error("events readback wrong");
  AST_STICKY: assert property (!rd_events && st_ff.events[EV_TARGET] |=>
    st_ff.events[EV_TARGET])
    else $error("event dropped without read");
  AST_IRQ: assert property (interrupt_output == |(st_ff.events & st_ff.int_sel))
    else $error("interrupt mismatch");
  AST_SPI: assert property (spi_status == (st_ff.events[7:0] & st_ff.spi_sel[7:0]))
    else $error("spi status mismatch");
  AST_RESET_EV: assert property ($fell(srst) |-> st_ff.events[EV_RESET])
    else $error("reset event missing");
  AST_FREEZE_EVENT: assert property (motion_freeze_event |=> motion_freeze_event && motion_neg_block
    && motion_pos_block)
    else $error("freeze released before reset");
  AST_LEFT_BLOCK: assert property (rise[EV_LEFT_SW] |=> motion_neg_block
    && st_ff.events[EV_LEFT_SW])
    else $error("left switch did not block");
  AST_RIGHT_HOLD: assert property (motion_pos_block && st_ff.events[EV_RIGHT_SW]
    && !st_ff.freeze_event && !hold_vr |=> motion_pos_block)
    else $error("right block released with event set");
  AST_SOFT_LEFT: assert property (rise[EV_LEFT_SOFT] |=> motion_neg_block)
    else $error("left soft limit did not block");
  AST_SOFT_RIGHT: assert property (rise[EV_RIGHT_SOFT] |=> motion_pos_block)
    else $error("right soft limit did not block");
  AST_SPD_POS: assert property ($changed(cond.speed_sign_code) &&
    cond.speed_sign_code == CODE_UP |=> st_ff.events[EV_SPD_POS])
    else $error("speed sign event missing");
  AST_RSVD: assert property (!st_ff.events[22])
    else $error("reserved bit set");

  AST_FREEZE_SET: assert property (rise[EV_FREEZE] |=>
    st_ff.events[EV_FREEZE] && motion_freeze_event)
    else $error("freeze event not latched");
  AST_LEFT_STAYS: assert property (st_ff.events[EV_LEFT_SW] |=> motion_neg_block)
    else $error("left block dropped with event set");
  AST_LEFT_FREE: assert property (s_left_sw_free |=> !hold_l)
    else $error("left block kept after release");
  AST_SOFT_L_STAYS: assert property (st_ff.events[EV_LEFT_SOFT] |=> motion_neg_block)
    else $error("left soft block dropped with event set");
  AST_SOFT_L_FREE: assert property (s_left_soft_free |=> !hold_vl)
    else $error("left soft block kept after disable");
  AST_SOFT_R_STAYS: assert property (st_ff.events[EV_RIGHT_SOFT] |=> motion_pos_block)
    else $error("right soft block dropped with event set");
  AST_WR_EVENTS: assert property (reg_req.wr && (reg_req.addr == ADDR_EVENTS) &&
    !reg_req.rd && (rise == ZERO_WORD) |=> (st_ff.events == $past(st_ff.events)))
    else $error("event register took a write");

endmodule

// file: sim/msev_host_model.sv
// host side of the register port: strobed read and write cycles
// assumes one core_clk domain; requests change 1 ns after a rising edge
module msev_host_model
  import msev_pkg::*;
(
  // clock
  input  wire logic          core_clk,
  // register access
  output msev_reg_req_t      reg_req,
  input  wire logic [31:0]   reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_req = '0;
  end

  // one-cycle strobe, taken at the next edge
  task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask

  // data is registered at the strobe edge, so it is picked up just after it
  task automatic rd_reg(input logic [6:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// file: sim/tb_motion_status_event_register.sv
// self-checking bench for the sticky motion event register
// assumes the host model drives the register port; conditions come from here
module tb_motion_status_event_register
  import msev_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          core_clk;
  logic          srst;
  msev_reg_req_t reg_req;
  logic [31:0]   reg_rdata;
  msev_cond_t    cond;
  logic [7:0]    spi_status;
  logic          irq;
  logic          neg_blk;
  logic          pos_blk;
  logic          freeze_event;
  int            n_fail;
  int            total_checks;
  int            cycles;
  logic [31:0]   r1;
  logic [31:0]   r2;
  int            ev_bit [20] = '{0, 1, 2, 9, 32, 15, 16, 17, 18, 19, 20, 21, 23, 24, 25,
                                 26, 27, 28, 29, 30};

  msev_top msev_top_inst (
    .core_clk(core_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cond(cond), .spi_status(spi_status), .interrupt_output(irq),
    .motion_neg_block(neg_blk), .motion_pos_block(pos_blk), .motion_freeze_event(freeze_event));

  msev_host_model msev_host_model_inst (
    .core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    msev_host_model_inst.rd_reg(a, r1);
    check_word(r1, exp);
  endtask

  function automatic msev_cond_t base_cond();
    msev_cond_t c;
    c = '0;
    c.freeze_input_n = 1'b1;
    return c;
  endfunction

  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // the whole run is under two hundred cycles; this is ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    cond = base_cond();
    step(10);
    srst = 1'b0;
    step(3);
    // zero speed and ramp codes at release count as rises
    rd_chk(ADDR_EVENTS, 32'h8000_0048);
    rd_chk(ADDR_EVENTS, 32'h0000_0000);
    for (int k = 1; k < 4; k++) begin
      cond.speed_sign_code = 2'(k % 3);
      cond.ramp_code = 2'(k % 3);
      step(1);
      rd_chk(ADDR_EVENTS, (32'h1 << (3 + k % 3)) | (32'h1 << (6 + k % 3)));
    end
    for (int i = 0; i < 20; i++) begin
      case (i)
        0: cond.target_hit = 1'b1;
        1: cond.pos_compare_hit = 1'b1;
        2: cond.top_speed_hit = 1'b1;
        3: begin
          cond.trap_at_limit = 1'b1;
          cond.break_speed = 32'h0000_0003;
          cond.present_speed = 32'hFFFF_FFFB;
        end
        4: cond.trap_at_limit = 1'b1;
        5: begin
          cond.home_mismatch = 1'b1;
          cond.home_outside_margin = 1'b1;
        end
        6: cond.position_capture_event = 1'b1;
        7: cond.fullstep_mode_event = 1'b1;
        8: cond.encoder_deviation_event = 1'b1;
        9: cond.index_event = 1'b1;
        10: cond.encoder_capture_event = 1'b1;
        11: cond.serial_encoder_error_event = 1'b1;
        12: cond.serial_encoder_config_event = 1'b1;
        13: cond.serial_encoder_flag_bits = 4'h4;
        14: cond.driver_datagram_sent = 1'b1;
        15: cond.encoder_speed_zero_event = 1'b1;
        16: cond.commutation_angle_limit_event = 1'b1;
        17: cond.loop_deviation_inner_event = 1'b1;
        18: cond.stall_stop = 1'b1;
        default: cond.driver_flag_event = 1'b1;
      endcase
      step(1);
      cond = base_cond();
      // entry 32 shifts the one out: a zero break speed must not set bit 9
      r2 = 32'h1 << ev_bit[i];
      rd_chk(ADDR_EVENTS, r2);
    end
    msev_host_model_inst.wr_reg(ADDR_PROTECT, 32'h0000_0001);
    msev_host_model_inst.wr_reg(ADDR_INT_SEL, 32'h0000_0004);
    msev_host_model_inst.wr_reg(ADDR_EVENTS, 32'hFFFF_FFFF);
    cond.target_hit = 1'b1;
    cond.top_speed_hit = 1'b1;
    step(1);
    cond = base_cond();
    step(3);
    check_bit(irq, 1'b1);
    check_word({24'h00_0000, spi_status}, 32'h0000_0005);
    rd_chk(ADDR_EVENTS, 32'h0000_0005);
    rd_chk(ADDR_EVENTS, 32'h0000_0001);
    check_bit(irq, 1'b0);
    check_word({24'h00_0000, spi_status}, 32'h0000_0001);
    rd_chk(ADDR_INT_SEL, 32'h0000_0004);
    msev_host_model_inst.wr_reg(ADDR_SPI_SEL, 32'h0000_0004);
    rd_chk(ADDR_SPI_SEL, 32'h0000_0004);
    check_word({24'h00_0000, spi_status}, 32'h0000_0000);
    rd_chk(7'h20, 32'h0000_0000);
    msev_host_model_inst.wr_reg(ADDR_PROTECT, 32'h0000_0000);
    rd_chk(ADDR_EVENTS, 32'h0000_0001);
    // a rise landing on the clearing read must survive into the next read
    fork
      msev_host_model_inst.rd_reg(ADDR_EVENTS, r2);
      begin
        step(0);
        @(posedge core_clk);
        #1;
        cond.pos_compare_hit = 1'b1;
      end
    join
    cond = base_cond();
    msev_host_model_inst.rd_reg(ADDR_EVENTS, r1);
    check_word(r1 | r2, 32'h0000_0002);
    cond.left_switch_en = 1'b1;
    cond.left_end_switch = 1'b1;
    step(2);
    check_bit(neg_blk, 1'b1);
    check_bit(pos_blk, 1'b0);
    rd_chk(ADDR_EVENTS, 32'h0000_0800);
    step(2);
    check_bit(neg_blk, 1'b1);
    cond.left_end_switch = 1'b0;
    step(2);
    check_bit(neg_blk, 1'b0);
    cond.right_switch_en = 1'b1;
    cond.right_end_switch = 1'b1;
    step(2);
    check_bit(pos_blk, 1'b1);
    cond.right_end_switch = 1'b0;
    step(2);
    check_bit(pos_blk, 1'b1);
    rd_chk(ADDR_EVENTS, 32'h0000_1000);
    step(1);
    check_bit(pos_blk, 1'b0);
    cond.right_limit_en = 1'b1;
    cond.right_soft_limit = 1'b1;
    step(2);
    check_bit(pos_blk, 1'b1);
    rd_chk(ADDR_EVENTS, 32'h0000_4000);
    cond.right_soft_limit = 1'b0;
    step(2);
    check_bit(pos_blk, 1'b1);
    cond.right_limit_written = 1'b1;
    step(1);
    cond.right_limit_written = 1'b0;
    step(2);
    check_bit(pos_blk, 1'b0);
    cond.left_limit_en = 1'b1;
    cond.left_soft_limit = 1'b1;
    step(2);
    check_bit(neg_blk, 1'b1);
    rd_chk(ADDR_EVENTS, 32'h0000_2000);
    cond.left_limit_en = 1'b0;
    step(2);
    check_bit(neg_blk, 1'b0);
    cond = base_cond();
    step(1);
    cond.freeze_input_n = 1'b0;
    step(2);
    check_bit(freeze_event, 1'b1);
    check_bit(neg_blk & pos_blk, 1'b1);
    rd_chk(ADDR_EVENTS, 32'h0000_0400);
    cond.freeze_input_n = 1'b1;
    step(3);
    check_bit(freeze_event, 1'b1);
    srst = 1'b1;
    step(10);
    srst = 1'b0;
    step(3);
    check_bit(freeze_event, 1'b0);
    rd_chk(ADDR_EVENTS, 32'h8000_0048);
    rd_chk(ADDR_SPI_SEL, 32'h8202_9805);
    rd_chk(ADDR_INT_SEL, 32'h0000_0000);
    give_verdict();
  end
endmodule
